/* logic/gric_pkg.sv */
// Purpose: Constants for the two-port pin remap, input gating and pin interrupt block
// Assumes: Registers sit at their full printed addresses on a plain register port
// Notes: Pin codes number port A pins 0..15 and port B pins 16..39
package gric_pkg;
	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] REMAP_ADDR = 32'h4000_1018;
	localparam logic [31:0] ANA_ADDR = 32'h4000_101a;
	localparam logic [31:0] PA_EN_ADDR = 32'h4000_1090;
	localparam logic [31:0] PB_EN_ADDR = 32'h4000_1092;
	localparam logic [31:0] PA_TRIG_ADDR = 32'h4000_1094;
	localparam logic [31:0] PB_TRIG_ADDR = 32'h4000_1096;
	localparam logic [31:0] PA_PEND_ADDR = 32'h4000_109c;
	localparam logic [31:0] PB_PEND_ADDR = 32'h4000_109e;
	localparam logic [31:0] PA_DIR_ADDR = 32'h4000_10a0;
	localparam logic [31:0] PA_PIN_ADDR = 32'h4000_10a4;
	localparam logic [31:0] PA_OUT_ADDR = 32'h4000_10a8;
	localparam logic [31:0] PA_CLR_ADDR = 32'h4000_10ac;
	localparam logic [31:0] PA_PU_ADDR = 32'h4000_10b0;
	localparam logic [31:0] PA_PD_ADDR = 32'h4000_10b4;
	localparam logic [31:0] PB_DIR_ADDR = 32'h4000_10c0;
	localparam logic [31:0] PB_PIN_ADDR = 32'h4000_10c4;
	localparam logic [31:0] PB_OUT_ADDR = 32'h4000_10c8;
	localparam logic [31:0] PB_CLR_ADDR = 32'h4000_10cc;
	localparam logic [31:0] PB_PU_ADDR = 32'h4000_10d0;
	localparam logic [31:0] PB_PD_ADDR = 32'h4000_10d4;
	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [15:0] RST16 = 16'h0000;
	localparam logic [23:0] RST24 = 24'h00_0000;
	localparam logic [31:0] RST32 = 32'h0000_0000;
	localparam logic [39:0] RST40 = 40'h00_0000_0000;
	localparam logic [15:0] REMAP_MASK = 16'h01ff;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int REMAP_SPI = 8;
	localparam int REMAP_UART0 = 4;
	localparam int REMAP_TMR0 = 0;
	localparam int ANA_CONV0 = 8;
	localparam int ANA_USB = 7;
	localparam int ANA_ETH = 6;
	localparam int ANA_SEG0 = 0;
	localparam int PB_BASE = 16;
	localparam int USB_PIN = 26;
	localparam int ETH_PIN = 28;
	// ----------------------------------------------------------------
	// Function pin codes, index is the unit number
	// ----------------------------------------------------------------
	localparam logic [5:0] URX_DEF [4] = '{6'h14, 6'h08, 6'h06, 6'h04};
	localparam logic [5:0] UTX_DEF [4] = '{6'h17, 6'h09, 6'h07, 6'h05};
	localparam logic [5:0] URX_ALT [4] = '{6'h0f, 6'h18, 6'h26, 6'h24};
	localparam logic [5:0] UTX_ALT [4] = '{6'h0e, 6'h19, 6'h27, 6'h25};
	localparam logic [5:0] TMR_DEF [4] = '{6'h03, 6'h0a, 6'h0b, 6'h02};
	localparam logic [5:0] TMR_ALT [4] = '{6'h23, 6'h1a, 6'h1b, 6'h22};
	localparam logic [5:0] SPI_DEF = 6'h0c;
	localparam logic [5:0] SPI_ALT = 6'h1c;
endpackage

/* logic/gric_top.sv */
// Purpose: Pin function remap, digital input gating and pin interrupts for ports A and B
// Assumes: One clock, asynchronous reset, registers written over a plain strobe port
// Notes: Function drive overrides the general output; pin outputs lag one clock
// Functional notes
// RQ1: Serial unit 0 on PB12-15 when set
// RQ2: Serial port 3 PB20/21, else PA4/5
// RQ3: Serial port 2 PB22/23, else PA6/7
// RQ4: Serial port 1 PB8/9, else PA8/9
// RQ5: Serial port 0 PA15/14, else PB4/7
// RQ6: Timer pins move from port A to B
// RQ7: Conversion bits gate port A pin pairs
// RQ8: Slow crystal bit gates PA10 and PA11
// RQ9: Serial bus bit claims PB10 and PB11
// RQ10: Network bit claims PB12 to PB15
// RQ11: Segment bits claim four port B pins
// RQ12: Software should gate analog pins' inputs
// RQ13: Per-pin interrupt enable on each port
// RQ14: Port A trigger bit: edge or level
// RQ15: Port B trigger bit: edge or level
// RQ16: Pending flags clear on write one
// RQ17: Input pin output bit sets polarity
// RQ18: Direction one drives, zero listens
// RQ19: Synchronise pins, flag only when enabled
// RQ20: Port request stays while flags pending
//
// The implementer's own choice: the plain strobed port.
module gric_top import gric_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	input wire logic [15:0] pa_in_i,
	input wire logic [23:0] pb_in_i,
	output logic [15:0] pa_out_o,
	output logic [15:0] pa_oe_o,
	output logic [23:0] pb_out_o,
	output logic [23:0] pb_oe_o,
	output logic [15:0] pa_pu_o,
	output logic [23:0] pb_pu_o,
	output logic [31:0] pa_pd_drv_o,
	output logic [31:0] pb_pd_drv_o,
	input wire logic [3:0] uart_tx_i,
	input wire logic [3:0] uart_tx_en_i,
	output logic [3:0] uart_rx_o,
	input wire logic [3:0] tmr_pwm_i,
	input wire logic [3:0] tmr_pwm_en_i,
	output logic [3:0] tmr_cap_o,
	input wire logic [3:0] spi_out_i,
	input wire logic [3:0] spi_oe_i,
	output logic [3:0] spi_in_o,
	output logic usb_pins_o,
	output logic eth_pins_o,
	output logic [5:0] seg_drive_o,
	output logic irq_a_o,
	output logic irq_b_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] remap, ana, a_en, b_en, a_trig, b_trig, a_dir, a_out;
	logic [23:0] b_dir, b_out;
	logic [15:0] next_remap, next_ana, next_a_en, next_b_en, next_a_trig, next_b_trig;
	logic [15:0] next_a_dir, next_a_out, next_a_pu;
	logic [23:0] next_b_dir, next_b_out, next_b_pu;
	logic [31:0] next_a_pd, next_b_pd, next_rdata;
	logic [39:0] sync1, sync2, prev, gate, g;
	logic [15:0] a_pend, b_pend, next_a_pend, next_b_pend, evt_a, evt_b;
	logic next_irq_a, next_irq_b;
	logic [39:0] fn_oe, fn_v, next_pin_v, next_pin_oe;
	logic [5:0] tx_p, rx_p, tp, sp;
	logic [3:0] next_rx, next_cap, next_spi;

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_comb begin
		next_remap = remap;
		next_ana = ana;
		next_a_en = a_en;
		next_b_en = b_en;
		next_a_trig = a_trig;
		next_b_trig = b_trig;
		next_a_dir = a_dir;
		next_b_dir = b_dir;
		next_a_out = a_out;
		next_b_out = b_out;
		next_a_pu = pa_pu_o;
		next_b_pu = pb_pu_o;
		next_a_pd = pa_pd_drv_o;
		next_b_pd = pb_pd_drv_o;
		if (we_i) begin
			case (addr_i)
				REMAP_ADDR: next_remap = wdata_i[15:0] & REMAP_MASK;
				ANA_ADDR: next_ana = wdata_i[15:0];
				PA_EN_ADDR: next_a_en = wdata_i[15:0]; // [RQ13]
				PB_EN_ADDR: next_b_en = wdata_i[15:0]; // [RQ13]
				PA_TRIG_ADDR: next_a_trig = wdata_i[15:0]; // [RQ14]
				PB_TRIG_ADDR: next_b_trig = wdata_i[15:0]; // [RQ15]
				PA_DIR_ADDR: next_a_dir = wdata_i[15:0];
				PB_DIR_ADDR: next_b_dir = wdata_i[23:0];
				PA_OUT_ADDR: next_a_out = wdata_i[15:0];
				PB_OUT_ADDR: next_b_out = wdata_i[23:0];
				PA_CLR_ADDR: next_a_out = a_out & ~wdata_i[15:0];
				PB_CLR_ADDR: next_b_out = b_out & ~wdata_i[23:0];
				PA_PU_ADDR: next_a_pu = wdata_i[15:0];
				PB_PU_ADDR: next_b_pu = wdata_i[23:0];
				PA_PD_ADDR: next_a_pd = wdata_i;
				PB_PD_ADDR: next_b_pd = wdata_i;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			remap <= RST16;
			ana <= RST16;
			a_en <= RST16;
			b_en <= RST16;
			a_trig <= RST16;
			b_trig <= RST16;
			a_dir <= RST16;
			b_dir <= RST24;
			a_out <= RST16;
			b_out <= RST24;
			pa_pu_o <= RST16;
			pb_pu_o <= RST24;
			pa_pd_drv_o <= RST32;
			pb_pd_drv_o <= RST32;
		end else begin
			remap <= next_remap;
			ana <= next_ana;
			a_en <= next_a_en;
			b_en <= next_b_en;
			a_trig <= next_a_trig;
			b_trig <= next_b_trig;
			a_dir <= next_a_dir;
			b_dir <= next_b_dir;
			a_out <= next_a_out;
			b_out <= next_b_out;
			pa_pu_o <= next_a_pu;
			pb_pu_o <= next_b_pu;
			pa_pd_drv_o <= next_a_pd;
			pb_pd_drv_o <= next_b_pd;
		end
	end

	// ----------------------------------------------------------------
	// Input gating
	// ----------------------------------------------------------------
	always_comb begin
		gate = RST40;
		for (int k = 0; k < 8; k++) begin
			gate[2*k +: 2] = {2{ana[ANA_CONV0+k]}}; // [RQ7] [RQ8]
		end
		for (int k = 0; k < 6; k++) begin
			gate[PB_BASE+4*k +: 4] = {4{ana[ANA_SEG0+k]}}; // [RQ11]
		end
		if (ana[ANA_USB]) begin
			gate[USB_PIN +: 2] = 2'h3; // [RQ9]
		end
		if (ana[ANA_ETH]) begin
			gate[ETH_PIN +: 4] = 4'hf; // [RQ10]
		end
	end

	// Gated pins read low so a floating analog level never toggles logic
	assign g = sync2 & ~gate;

	// ----------------------------------------------------------------
	// Pin interrupts
	// ----------------------------------------------------------------
	function automatic logic [15:0] pin_evt(input logic [15:0] cur, input logic [15:0] old,
		input logic [15:0] en, input logic [15:0] dir, input logic [15:0] trig, input logic [15:0] pol);
		pin_evt = en & ~dir & ~(cur ^ pol) & (~trig | (cur ^ old)); // [RQ17] [RQ19]
	endfunction

	assign evt_a = pin_evt(g[15:0], prev[15:0], a_en, a_dir, a_trig, a_out); // [RQ14]
	assign evt_b = pin_evt(g[31:16], prev[31:16], b_en, b_dir[15:0], b_trig, b_out[15:0]); // [RQ15]

	always_comb begin
		next_a_pend = a_pend;
		next_b_pend = b_pend;
		if (we_i && addr_i == PA_PEND_ADDR) begin
			next_a_pend = a_pend & ~wdata_i[15:0]; // [RQ16]
		end
		if (we_i && addr_i == PB_PEND_ADDR) begin
			next_b_pend = b_pend & ~wdata_i[15:0]; // [RQ16]
		end
		// A new event beats a clear in the same cycle
		next_a_pend = next_a_pend | evt_a;
		next_b_pend = next_b_pend | evt_b;
		next_irq_a = |next_a_pend; // [RQ20]
		next_irq_b = |next_b_pend; // [RQ20]
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1 <= RST40;
			sync2 <= RST40;
			prev <= RST40;
			a_pend <= RST16;
			b_pend <= RST16;
			irq_a_o <= 1'b0;
			irq_b_o <= 1'b0;
		end else begin
			sync1 <= {pb_in_i, pa_in_i}; // [RQ19]
			sync2 <= sync1;
			prev <= g;
			a_pend <= next_a_pend;
			b_pend <= next_b_pend;
			irq_a_o <= next_irq_a;
			irq_b_o <= next_irq_b;
		end
	end

	// ----------------------------------------------------------------
	// Function routing and pin drive
	// ----------------------------------------------------------------
	always_comb begin
		fn_oe = RST40;
		fn_v = RST40;
		next_rx = 4'h0;
		next_cap = 4'h0;
		next_spi = 4'h0;
		tx_p = UTX_DEF[0];
		rx_p = URX_DEF[0];
		tp = TMR_DEF[0];
		sp = SPI_DEF;
		for (int k = 0; k < 4; k++) begin
			tx_p = remap[REMAP_UART0+k] ? UTX_ALT[k] : UTX_DEF[k]; // [RQ2] [RQ3] [RQ4] [RQ5]
			rx_p = remap[REMAP_UART0+k] ? URX_ALT[k] : URX_DEF[k];
			// A function that does not ask for the pin leaves it to any earlier owner
			if (uart_tx_en_i[k]) begin
				fn_oe[tx_p] = 1'b1;
				fn_v[tx_p] = uart_tx_i[k];
			end
			next_rx[k] = g[rx_p];
			tp = remap[REMAP_TMR0+k] ? TMR_ALT[k] : TMR_DEF[k]; // [RQ6]
			if (tmr_pwm_en_i[k]) begin
				fn_oe[tp] = 1'b1;
				fn_v[tp] = tmr_pwm_i[k];
			end
			next_cap[k] = g[tp];
			sp = (remap[REMAP_SPI] ? SPI_ALT : SPI_DEF) + 6'(k); // [RQ1]
			if (spi_oe_i[k]) begin
				fn_oe[sp] = 1'b1;
				fn_v[sp] = spi_out_i[k];
			end
			next_spi[k] = g[sp];
		end
		next_pin_v = (fn_oe & fn_v) | (~fn_oe & {b_out, a_out});
		// Pins handed to the transceivers or segment drive lose general drive
		next_pin_oe = fn_oe | ({b_dir, a_dir} & ~{gate[39:16], RST16}); // [RQ18]
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = RST32;
		if (re_i) begin
			case (addr_i)
				REMAP_ADDR: next_rdata = 32'(remap);
				ANA_ADDR: next_rdata = 32'(ana);
				PA_EN_ADDR: next_rdata = 32'(a_en);
				PB_EN_ADDR: next_rdata = 32'(b_en);
				PA_TRIG_ADDR: next_rdata = 32'(a_trig);
				PB_TRIG_ADDR: next_rdata = 32'(b_trig);
				PA_PEND_ADDR: next_rdata = 32'(a_pend);
				PB_PEND_ADDR: next_rdata = 32'(b_pend);
				PA_DIR_ADDR: next_rdata = 32'(a_dir);
				PB_DIR_ADDR: next_rdata = 32'(b_dir);
				PA_PIN_ADDR: next_rdata = 32'(g[15:0]);
				PB_PIN_ADDR: next_rdata = 32'(g[39:16]);
				PA_OUT_ADDR: next_rdata = 32'(a_out);
				PB_OUT_ADDR: next_rdata = 32'(b_out);
				PA_PU_ADDR: next_rdata = 32'(pa_pu_o);
				PB_PU_ADDR: next_rdata = 32'(pb_pu_o);
				PA_PD_ADDR: next_rdata = pa_pd_drv_o;
				PB_PD_ADDR: next_rdata = pb_pd_drv_o;
				default: next_rdata = RST32;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= RST32;
			pa_out_o <= RST16;
			pa_oe_o <= RST16;
			pb_out_o <= RST24;
			pb_oe_o <= RST24;
			uart_rx_o <= 4'h0;
			tmr_cap_o <= 4'h0;
			spi_in_o <= 4'h0;
			usb_pins_o <= 1'b0;
			eth_pins_o <= 1'b0;
			seg_drive_o <= 6'h00;
		end else begin
			rdata_o <= next_rdata;
			pa_out_o <= next_pin_v[15:0];
			pa_oe_o <= next_pin_oe[15:0];
			pb_out_o <= next_pin_v[39:16];
			pb_oe_o <= next_pin_oe[39:16];
			uart_rx_o <= next_rx;
			tmr_cap_o <= next_cap;
			spi_in_o <= next_spi;
			usb_pins_o <= ana[ANA_USB]; // [RQ9]
			eth_pins_o <= ana[ANA_ETH]; // [RQ10]
			seg_drive_o <= ana[ANA_SEG0 +: 6]; // [RQ11]
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_pend_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ16]
		(we_i && addr_i == PA_PEND_ADDR) |=> ((a_pend & $past(evt_a)) == $past(evt_a)))
		else $error("pending event lost under clear");
	a_pend_w1c_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ16]
		(we_i && addr_i == PA_PEND_ADDR) |=> ((a_pend & $past(wdata_i[15:0] & ~evt_a)) == RST16))
		else $error("write one did not clear flag");
	a_irq_follows_pend: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ20]
		irq_b_o == (b_pend != RST16))
		else $error("port b request disagrees with flags");
	a_enable_gates_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ19]
		(a_en == RST16 && a_pend == RST16) |=> (a_pend == RST16))
		else $error("flag set while disabled");
	a_level_sets_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ14]
		(a_en[5] && !a_trig[5] && !a_dir[5] && g[5] == a_out[5]) |=> (a_pend[5] && irq_a_o))
		else $error("level match did not raise request");
	a_spi_remap_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ1]
		(remap[REMAP_SPI] && spi_oe_i[0]) |=> (pb_oe_o[12] && pb_out_o[12] == $past(spi_out_i[0])))
		else $error("serial unit clock not on port b");
	a_uart0_default: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ5]
		(!remap[REMAP_UART0] && uart_tx_en_i[0]) |=> (pb_oe_o[7] && pb_out_o[7] == $past(uart_tx_i[0])))
		else $error("serial port 0 transmit not on PB7");
	a_gate_reads_low: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ7]
		(re_i && addr_i == PA_PIN_ADDR && ana[ANA_CONV0]) |=> (rdata_o[1:0] == 2'h0))
		else $error("gated pins read high");
	a_dir_drives_pin: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ18]
		(a_dir[0] && !fn_oe[0]) |=> (pa_oe_o[0] && pa_out_o[0] == $past(a_out[0])))
		else $error("output direction not driving");
	a_usb_drops_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ9]
		(ana[ANA_USB] && !fn_oe[USB_PIN]) |=> !pb_oe_o[USB_PIN - PB_BASE])
		else $error("serial bus pin still driven");
	a_eth_drops_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ10]
		(ana[ANA_ETH] && !fn_oe[ETH_PIN]) |=> !pb_oe_o[ETH_PIN - PB_BASE])
		else $error("network pin still driven");
	a_seg_gates_input: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ11]
		(re_i && addr_i == PB_PIN_ADDR && ana[ANA_SEG0]) |=> (rdata_o[3:0] == 4'h0))
		else $error("segment pins read high");
	a_crystal_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ8]
		(re_i && addr_i == PA_PIN_ADDR && ana[ANA_CONV0 + 5]) |=> (rdata_o[11:10] == 2'h0))
		else $error("crystal pins read high");
	a_timer0_remap: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ6]
		(remap[REMAP_TMR0] && tmr_pwm_en_i[0]) |=> (pb_oe_o[19] && pb_out_o[19] == $past(tmr_pwm_i[0])))
		else $error("timer 0 output not on PB19");
	a_uart1_rx_alt: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ4]
		remap[REMAP_UART0 + 1] |=> (uart_rx_o[1] == $past(g[URX_ALT[1]])))
		else $error("serial port 1 receive not from PB8");
	a_spi_default_in: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ1]
		!remap[REMAP_SPI] |=> (spi_in_o[3] == $past(g[SPI_DEF + 6'd3])))
		else $error("serial unit data in not from PA15");
	a_pb_edge_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ15]
		(b_en[2] && b_trig[2] && !b_dir[2] && !b_out[2] && prev[18] && !g[18]) |=> b_pend[2])
		else $error("port b falling edge lost");
	a_pb_w1c_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ16]
		(we_i && addr_i == PB_PEND_ADDR) |=> ((b_pend & $past(wdata_i[15:0] & ~evt_b)) == RST16))
		else $error("port b write one did not clear");
	a_pb_enable_gates: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RQ13]
		(b_en == RST16 && b_pend == RST16) |=> (b_pend == RST16))
		else $error("port b flag set while disabled");
endmodule

/* verification/gric_pins.sv */
// Purpose: Pin-side partner, joins block drive and outside levels
// Assumes: One bit per pin, port A on 15..0, port B on 39..16
// Notes: An undriven pin shows the level the bench sets, never a held one
module gric_pins (
	input wire logic [39:0] out_i,
	input wire logic [39:0] oe_i,
	input wire logic [39:0] ext_i,
	output logic [39:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Block drive wins where it drives, else the outside level
	assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

/* verification/tb.sv */
// Purpose: Self-checking bench for pin remap, input gating and pin interrupts
// Assumes: 20 MHz clock, reset high for 20 cycles
// Notes: Pin codes index {port B, port A} as one 40-bit vector
module tb import gric_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] addr = '0;
	logic [31:0] wdata = '0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [3:0] utx = 4'hf, uen = '0, tpw = 4'hf, ten = '0, sout = 4'hf, soe = '0;
	logic [39:0] ext = '0;
	wire logic [39:0] pout, poe, pins;
	logic [31:0] rdata;
	logic [3:0] urx, tcap, sin;
	logic [5:0] seg;
	logic usb, eth, irq_a, irq_b;
	int err_count = 0;
	int comparisons = 0;
	always #25 clk = ~clk;
	gric_top DUT (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
		.rdata_o(rdata), .pa_in_i(pins[15:0]), .pb_in_i(pins[39:16]), .pa_out_o(pout[15:0]),
		.pa_oe_o(poe[15:0]), .pb_out_o(pout[39:16]), .pb_oe_o(poe[39:16]), .pa_pu_o(), .pb_pu_o(),
		.pa_pd_drv_o(), .pb_pd_drv_o(), .uart_tx_i(utx), .uart_tx_en_i(uen), .uart_rx_o(urx),
		.tmr_pwm_i(tpw), .tmr_pwm_en_i(ten), .tmr_cap_o(tcap), .spi_out_i(sout), .spi_oe_i(soe),
		.spi_in_o(sin), .usb_pins_o(usb), .eth_pins_o(eth), .seg_drive_o(seg), .irq_a_o(irq_a),
		.irq_b_o(irq_b));
	gric_pins pm (.out_i(pout), .oe_i(poe), .ext_i(ext), .pin_o(pins));
	// ----
	// Bus and compare tasks
	// ----
	task automatic chk(input string what, input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		chk(what, 40'(rdata), 40'(exp));
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		logic [31:0] a [8] = '{REMAP_ADDR, ANA_ADDR, PA_EN_ADDR, PB_TRIG_ADDR, PA_PEND_ADDR, PB_DIR_ADDR,
			PA_OUT_ADDR, PB_PD_ADDR};
		foreach (a[i]) rchk("reset value", a[i], RST32);
		wr(32'h4000_1000, 32'hffff_ffff);
		rchk("unmapped", 32'h4000_1000, RST32);
		$display("test reset done");
	endtask
	task automatic t_remap();
		logic [5:0] tp, op, mp;
		wr(REMAP_ADDR, 32'h0000_ffff);
		rchk("remap bits", REMAP_ADDR, 32'(REMAP_MASK));
		for (int k = 0; k < 4; k++) begin
			for (int s = 0; s < 2; s++) begin
				wr(REMAP_ADDR, 32'(s << (REMAP_UART0 + k)) | 32'(s << (REMAP_TMR0 + k)));
				tp = s ? UTX_ALT[k] : UTX_DEF[k];
				op = s ? UTX_DEF[k] : UTX_ALT[k];
				mp = s ? TMR_ALT[k] : TMR_DEF[k];
				@(posedge clk);
				uen <= 4'(1 << k);
				ten <= 4'(1 << k);
				ext <= 40'(1) << (s ? URX_ALT[k] : URX_DEF[k]);
				settle(5);
				chk("uart tx pin", 40'({poe[tp], pout[tp], poe[op]}), 40'(6));
				chk("uart rx", 40'(urx[k]), 40'(1));
				chk("timer pin", 40'({poe[mp], pout[mp], tcap[k]}), 40'(7));
			end
		end
		@(posedge clk);
		uen <= '0;
		ten <= '0;
		for (int s = 0; s < 2; s++) begin
			wr(REMAP_ADDR, 32'(s << REMAP_SPI));
			tp = s ? SPI_ALT : SPI_DEF;
			@(posedge clk);
			soe <= 4'h1;
			ext <= 40'(1) << (tp + 6'd3);
			settle(5);
			chk("spi pins", 40'({poe[tp], pout[tp], sin[3], sin[0]}), 40'hf);
		end
		@(posedge clk);
		soe <= '0;
		wr(REMAP_ADDR, RST32);
		$display("test remap done");
	endtask
	task automatic t_gate();
		logic [15:0] m;
		logic [23:0] m24;
		@(posedge clk);
		ext <= '1;
		// Analog pins get their inputs gated before use
		for (int b = 8; b < 16; b++) begin
			wr(ANA_ADDR, 32'(1 << b));
			m = ~(16'h3 << (2 * (b - 8)));
			settle(3);
			rchk("pa pins", PA_PIN_ADDR, 32'(m));
		end
		for (int b = 0; b < 6; b++) begin
			wr(ANA_ADDR, 32'(1 << b));
			m24 = ~(24'hf << (4 * b));
			settle(3);
			rchk("pb pins", PB_PIN_ADDR, 32'(m24));
			chk("seg drive", 40'(seg), 40'(1 << b));
		end
		wr(PB_DIR_ADDR, 32'h00_fc00);
		wr(ANA_ADDR, 32'h0000_00c0);
		settle(3);
		chk("usb eth", 40'({usb, eth, seg}), 40'h0c0);
		chk("usb eth drive", 40'(poe[31:26]), 40'h0);
		rchk("usb eth pins", PB_PIN_ADDR, 32'h00ff_03ff);
		wr(ANA_ADDR, RST32);
		settle(2);
		chk("drive back", 40'(poe[31:26]), 40'h3f);
		wr(PB_DIR_ADDR, RST32);
		@(posedge clk);
		ext <= '0;
		$display("test gate done");
	endtask
	task automatic t_irq();
		@(posedge clk);
		ext <= 40'h20;
		wr(PA_OUT_ADDR, 32'h48);
		wr(PA_TRIG_ADDR, 32'h8);
		wr(PA_EN_ADDR, 32'h28);
		settle(5);
		chk("irq a quiet", 40'(irq_a), 40'(0));
		@(posedge clk);
		ext <= 40'h68;
		settle(5);
		chk("irq a", 40'(irq_a), 40'(1));
		rchk("pend a", PA_PEND_ADDR, 32'h8);
		wr(PA_PEND_ADDR, 32'h0);
		rchk("pend kept", PA_PEND_ADDR, 32'h8);
		wr(PA_PEND_ADDR, 32'h8);
		rchk("pend cleared", PA_PEND_ADDR, 32'h0);
		chk("irq a off", 40'(irq_a), 40'(0));
		@(posedge clk);
		ext <= 40'h48;
		settle(5);
		wr(PA_PEND_ADDR, 32'h20);
		rchk("level again", PA_PEND_ADDR, 32'h20);
		@(posedge clk);
		ext <= 40'h68;
		settle(4);
		wr(PA_PEND_ADDR, 32'h20);
		rchk("level gone", PA_PEND_ADDR, 32'h0);
		wr(PA_EN_ADDR, 32'h0);
		@(posedge clk);
		ext <= 40'h4_0000;
		wr(PB_TRIG_ADDR, 32'h4);
		wr(PB_EN_ADDR, 32'h4);
		settle(5);
		chk("irq b quiet", 40'(irq_b), 40'(0));
		@(posedge clk);
		ext <= '0;
		settle(5);
		chk("irq b", 40'(irq_b), 40'(1));
		rchk("pend b", PB_PEND_ADDR, 32'h4);
		wr(PB_PEND_ADDR, 32'h4);
		settle(2);
		chk("irq b off", 40'(irq_b), 40'(0));
		$display("test irq done");
	endtask
	task automatic t_gpio();
		wr(PA_DIR_ADDR, 32'h1);
		wr(PA_OUT_ADDR, 32'h1);
		wr(PB_DIR_ADDR, 32'h80_0000);
		wr(PB_OUT_ADDR, 32'h80_0000);
		settle(2);
		chk("drive", 40'({poe[39], pout[39], poe[0], pout[0]}), 40'hf);
		wr(PA_CLR_ADDR, 32'h1);
		rchk("clear reads", PA_CLR_ADDR, RST32);
		rchk("out cleared", PA_OUT_ADDR, RST32);
		chk("pin low", 40'({poe[0], pout[0]}), 40'h2);
		$display("test gpio done");
	endtask
	// ----
	// Run control
	// ----
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_remap();
		t_gate();
		t_irq();
		t_gpio();
		test_done();
	end
	// Whole run needs well under 2000 cycles
	initial begin
		#(20000 * 50);
		err_count++;
		test_done();
	end
endmodule
